// [core/ubmu_pkg.sv]
// Package for the user break match unit: register map, field layout,
// bus cycle codes and the packed carriers for the two watched buses.
// Assumes a single 25 MHz clock and a plain strobe register port.
`default_nettype none

package ubmu_pkg;

   // ------------------------------------------------------------
   // Register offsets (word index on the register port)
   // ------------------------------------------------------------
   localparam logic [4:0] A_BRK_ADDR = 5'h00;
   localparam logic [4:0] A_ADDR_MSK = 5'h01;
   localparam logic [4:0] A_BRK_DATA = 5'h02;
   localparam logic [4:0] A_DATA_MSK = 5'h03;
   localparam logic [4:0] A_CYC_COND = 5'h04;
   localparam logic [4:0] B_BRK_ADDR = 5'h08;
   localparam logic [4:0] B_ADDR_MSK = 5'h09;
   localparam logic [4:0] B_BRK_DATA = 5'h0A;
   localparam logic [4:0] B_DATA_MSK = 5'h0B;
   localparam logic [4:0] B_CYC_COND = 5'h0C;
   localparam logic [4:0] BRK_CTRL = 5'h10;
   localparam logic [4:0] IRQ_MASK = 5'h11;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   // Cycle condition: [1:0] bus sel, [3:2] fetch/data, [5:4] rd/wr,
   // [8:6] system bus master select
   localparam int CC_BUS_LSB = 0;
   localparam int CC_FD_LSB = 2;
   localparam int CC_RW_LSB = 4;
   localparam int CC_MS_LSB = 6;
   localparam int CC_WIDTH = 9;
   // Break control: [0] A local and [2] A system both set by any channel A hit, [1] B local and [3] B system by any B hit
   localparam int BC_A_LOC = 0;
   localparam int BC_B_LOC = 1;
   localparam int BC_A_SYS = 2;
   localparam int BC_B_SYS = 3;
   localparam int BC_WIDTH = 4;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [CC_WIDTH-1:0] RST_CC = 9'h000;
   localparam logic [BC_WIDTH-1:0] RST_BC = 4'h0;

   // Two-bit group codes: bit0 selects first choice, bit1 second
   localparam logic [1:0] GRP_OFF = 2'h0;
   localparam int GRP_FIRST = 0; // local bus / fetch / read
   localparam int GRP_SECOND = 1; // system bus / data / write

   // System bus master ids (one-hot positions in master select)
   localparam logic [1:0] MST_CPU = 2'h0;
   localparam logic [1:0] MST_XFER = 2'h1;
   localparam logic [1:0] MST_OTHER = 2'h2;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [31:0] data;
      logic write;
      logic fetch;
   } ubmu_lbus_s;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [31:0] data;
      logic write;
      logic [1:0] master;
      logic fetch_fill; // caused by a CPU local-bus instruction fetch
   } ubmu_sbus_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] addr_msk;
      logic [31:0] data;
      logic [31:0] data_msk;
      logic [CC_WIDTH-1:0] cond;
   } ubmu_chan_s;

endpackage

`default_nettype wire

// [core/ubmu_top.sv]
// User break match unit: two channels watching the local bus and the
// system bus, with sticky match flags and one break request.
// Assumes bus cycles are presented as one-cycle valid beats that are
// synchronous to clock_i; registers sit behind a plain strobe port.
`default_nettype none

module ubmu_top (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire ubmu_pkg::ubmu_lbus_s lbus_i,
   input wire ubmu_pkg::ubmu_sbus_s sbus_i,
   output logic break_req_o,
   output logic irq_o
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   ubmu_pkg::ubmu_chan_s chan [2];
   ubmu_pkg::ubmu_chan_s next_chan [2];
   logic [ubmu_pkg::BC_WIDTH-1:0] flags;
   logic [ubmu_pkg::BC_WIDTH-1:0] next_flags;
   logic [ubmu_pkg::BC_WIDTH-1:0] mask;
   logic [ubmu_pkg::BC_WIDTH-1:0] next_mask;
   logic [31:0] next_rdata;
   logic break_req;
   logic next_break_req;
   logic [1:0] hit_loc;
   logic [1:0] hit_sys;

   // ------------------------------------------------------------
   // Per-channel comparators
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         logic [1:0] bus_sel;
         logic [1:0] fd_sel;
         logic [1:0] rw_sel;
         logic [2:0] mst_sel;
         logic armed;
         logic l_addr_ok;
         logic l_data_ok;
         logic s_addr_ok;
         logic s_data_ok;
         logic s_fetch;
         logic l_cyc_ok;
         logic s_cyc_ok;

         assign bus_sel = chan[g].cond[ubmu_pkg::CC_BUS_LSB +: 2];
         assign fd_sel = chan[g].cond[ubmu_pkg::CC_FD_LSB +: 2];
         assign rw_sel = chan[g].cond[ubmu_pkg::CC_RW_LSB +: 2];
         assign mst_sel = chan[g].cond[ubmu_pkg::CC_MS_LSB +: 3];

         assign armed = (bus_sel != ubmu_pkg::GRP_OFF)
            && (fd_sel != ubmu_pkg::GRP_OFF)
            && (rw_sel != ubmu_pkg::GRP_OFF);

         assign l_addr_ok =
            ((lbus_i.addr ^ chan[g].addr) & ~chan[g].addr_msk) == 32'h0;
         assign s_addr_ok =
            ((sbus_i.addr ^ chan[g].addr) & ~chan[g].addr_msk) == 32'h0;
         assign l_data_ok =
            ((lbus_i.data ^ chan[g].data) & ~chan[g].data_msk) == 32'h0;
         assign s_data_ok =
            ((sbus_i.data ^ chan[g].data) & ~chan[g].data_msk) == 32'h0;

         assign s_fetch = sbus_i.fetch_fill
            && (sbus_i.master != ubmu_pkg::MST_XFER);

         assign l_cyc_ok = bus_sel[ubmu_pkg::GRP_FIRST]
            && fd_sel[lbus_i.fetch ? ubmu_pkg::GRP_FIRST
                                   : ubmu_pkg::GRP_SECOND]
            && rw_sel[lbus_i.write ? ubmu_pkg::GRP_SECOND
                                   : ubmu_pkg::GRP_FIRST];
         // selected masters only
         // Master id 3 names no master, so it is never selected
         assign s_cyc_ok = bus_sel[ubmu_pkg::GRP_SECOND]
            && (sbus_i.master <= ubmu_pkg::MST_OTHER)
            && mst_sel[sbus_i.master]
            && fd_sel[s_fetch ? ubmu_pkg::GRP_FIRST
                              : ubmu_pkg::GRP_SECOND]
            && rw_sel[sbus_i.write ? ubmu_pkg::GRP_SECOND
                                   : ubmu_pkg::GRP_FIRST];

         assign hit_loc[g] = armed && lbus_i.valid && l_cyc_ok
            && l_addr_ok && l_data_ok;
         assign hit_sys[g] = armed && sbus_i.valid && s_cyc_ok
            && s_addr_ok && s_data_ok;
      end
   endgenerate

   // ------------------------------------------------------------
   // Register writes, flags and break request
   // ------------------------------------------------------------
   // Flag set wins over a clearing write in the same cycle, so a
   // match arriving during software clear is never lost.
   always_comb begin
      next_chan = chan;
      next_mask = mask;
      next_flags = flags;
      if (reg_wr_i) begin
         case (reg_addr_i)
            ubmu_pkg::A_BRK_ADDR: next_chan[0].addr = reg_wdata_i;
            ubmu_pkg::A_ADDR_MSK: next_chan[0].addr_msk = reg_wdata_i;
            ubmu_pkg::A_BRK_DATA: next_chan[0].data = reg_wdata_i;
            ubmu_pkg::A_DATA_MSK: next_chan[0].data_msk = reg_wdata_i;
            ubmu_pkg::A_CYC_COND: begin
               next_chan[0].cond = reg_wdata_i[ubmu_pkg::CC_WIDTH-1:0];
            end
            ubmu_pkg::B_BRK_ADDR: next_chan[1].addr = reg_wdata_i;
            ubmu_pkg::B_ADDR_MSK: next_chan[1].addr_msk = reg_wdata_i;
            ubmu_pkg::B_BRK_DATA: next_chan[1].data = reg_wdata_i;
            ubmu_pkg::B_DATA_MSK: next_chan[1].data_msk = reg_wdata_i;
            ubmu_pkg::B_CYC_COND: begin
               next_chan[1].cond = reg_wdata_i[ubmu_pkg::CC_WIDTH-1:0];
            end
            ubmu_pkg::BRK_CTRL: begin
               next_flags = flags & reg_wdata_i[ubmu_pkg::BC_WIDTH-1:0];
            end
            ubmu_pkg::IRQ_MASK: begin
               next_mask = reg_wdata_i[ubmu_pkg::BC_WIDTH-1:0];
            end
            default: ;
         endcase
      end
      if (hit_loc[0] || hit_sys[0]) begin
         next_flags[ubmu_pkg::BC_A_LOC] = 1'b1;
         next_flags[ubmu_pkg::BC_A_SYS] = 1'b1;
      end
      if (hit_loc[1] || hit_sys[1]) begin
         next_flags[ubmu_pkg::BC_B_LOC] = 1'b1;
         next_flags[ubmu_pkg::BC_B_SYS] = 1'b1;
      end
      // break lands near, not on, the cycle
      next_break_req = (|hit_loc) || (|hit_sys);
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            ubmu_pkg::A_BRK_ADDR: next_rdata = chan[0].addr;
            ubmu_pkg::A_ADDR_MSK: next_rdata = chan[0].addr_msk;
            ubmu_pkg::A_BRK_DATA: next_rdata = chan[0].data;
            ubmu_pkg::A_DATA_MSK: next_rdata = chan[0].data_msk;
            ubmu_pkg::A_CYC_COND: next_rdata = {23'h0, chan[0].cond};
            ubmu_pkg::B_BRK_ADDR: next_rdata = chan[1].addr;
            ubmu_pkg::B_ADDR_MSK: next_rdata = chan[1].addr_msk;
            ubmu_pkg::B_BRK_DATA: next_rdata = chan[1].data;
            ubmu_pkg::B_DATA_MSK: next_rdata = chan[1].data_msk;
            ubmu_pkg::B_CYC_COND: next_rdata = {23'h0, chan[1].cond};
            ubmu_pkg::BRK_CTRL: next_rdata = {28'h0, flags};
            ubmu_pkg::IRQ_MASK: next_rdata = {28'h0, mask};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   // Channels reset with zero cycle condition, hence disarmed until
   // software writes the condition register last.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 2; i++) begin
            chan[i].addr <= ubmu_pkg::RST_WORD;
            chan[i].addr_msk <= ubmu_pkg::RST_WORD;
            chan[i].data <= ubmu_pkg::RST_WORD;
            chan[i].data_msk <= ubmu_pkg::RST_WORD;
            chan[i].cond <= ubmu_pkg::RST_CC;
         end
         flags <= ubmu_pkg::RST_BC;
         mask <= ubmu_pkg::RST_BC;
         reg_rdata_o <= ubmu_pkg::RST_WORD;
         break_req <= 1'b0;
      end else begin
         chan <= next_chan;
         flags <= next_flags;
         mask <= next_mask;
         reg_rdata_o <= next_rdata;
         break_req <= next_break_req;
      end
   end

   assign break_req_o = break_req;
   // Level interrupt while any unmasked flag stands
   assign irq_o = |(flags & mask);

endmodule

`default_nettype wire

// [verif/ubmu_top_props.sv]
// Port checker for the user break match unit.
// Assumes one clock domain and the synchronous active-low reset.
`default_nettype none
module ubmu_top_props (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire ubmu_pkg::ubmu_lbus_s lbus_i,
   input wire ubmu_pkg::ubmu_sbus_s sbus_i,
   input wire logic break_req_o,
   input wire logic irq_o
);
   // ------------------------------------------------------------
   // Shadow of both cycle conditions
   // ------------------------------------------------------------
   localparam int MS = ubmu_pkg::CC_MS_LSB;
   localparam int FD = ubmu_pkg::CC_FD_LSB;
   logic [8:0] ca, cb, next_ca, next_cb;
   logic so, sel_m, arm;
   // Track writes so the checker knows which settings are live
   always_comb begin
      next_ca = ca;
      next_cb = cb;
      if (reg_wr_i && reg_addr_i == ubmu_pkg::A_CYC_COND) begin
         next_ca = reg_wdata_i[8:0];
      end
      if (reg_wr_i && reg_addr_i == ubmu_pkg::B_CYC_COND) begin
         next_cb = reg_wdata_i[8:0];
      end
   end
   always_ff @(posedge clock_i) begin
      ca <= rst_n_i ? next_ca : 9'h000;
      cb <= rst_n_i ? next_cb : 9'h000;
   end
   // System beat alone, so any request must come from it
   assign so = sbus_i.valid && !lbus_i.valid;
   assign sel_m = ca[MS + sbus_i.master] || cb[MS + sbus_i.master];
   assign arm = (|ca[1:0] && |ca[3:2] && |ca[5:4])
      || (|cb[1:0] && |cb[3:2] && |cb[5:4]);
   default clocking cb_clk @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_break_cause: assert property (
      break_req_o |-> $past(lbus_i.valid || sbus_i.valid))
      else $error("break request without a bus beat");
   a_disarmed_quiet: assert property (
      break_req_o |-> $past(arm)) else $error("break while disarmed");
   a_one_request: assert property (
      (lbus_i.valid || sbus_i.valid) ##1 !(lbus_i.valid || sbus_i.valid)
      |=> !break_req_o) else $error("break request too long");
   a_irq_rise: assert property (
      $rose(irq_o) |-> break_req_o
      || $past(reg_wr_i && reg_addr_i == ubmu_pkg::IRQ_MASK))
      else $error("interrupt rose without cause");
   a_irq_hold: assert property (
      irq_o && !reg_wr_i |=> irq_o) else $error("interrupt dropped");
   a_master_filter: assert property (
      so && !sel_m |=> !break_req_o) else $error("unselected master hit");
   a_fill_fetch: assert property (
      so && sbus_i.fetch_fill && sbus_i.master == ubmu_pkg::MST_CPU
      && !ca[FD] && !cb[FD] |=> !break_req_o)
      else $error("fill cycle seen as data");
   a_xfer_data: assert property (
      so && sbus_i.master == ubmu_pkg::MST_XFER && !ca[FD + 1]
      && !cb[FD + 1] |=> !break_req_o) else $error("transfer as fetch");
   c_break: cover property (break_req_o);
   c_both: cover property (lbus_i.valid && sbus_i.valid ##1 break_req_o);
   c_irq: cover property ($rose(irq_o));
endmodule
bind ubmu_top ubmu_top_props props_u (.clock_i(clock_i),
   .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .lbus_i(lbus_i), .sbus_i(sbus_i), .break_req_o(break_req_o),
   .irq_o(irq_o));
`default_nettype wire

// [verif/ubmu_bus_model.sv]
// Model of the masters on both watched buses: one beat, then idle.
// Assumes the bench calls beat() and samples results on return.
`default_nettype none
module ubmu_bus_model (
   input wire logic clock_i,
   output var ubmu_pkg::ubmu_lbus_s lbus_o,
   output var ubmu_pkg::ubmu_sbus_s sbus_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      lbus_o = '0;
      sbus_o = '0;
   end
   // Idle fields show the inverse so a stale beat can never match
   task automatic beat(input ubmu_pkg::ubmu_lbus_s l,
         input ubmu_pkg::ubmu_sbus_s s);
      ubmu_pkg::ubmu_lbus_s li;
      ubmu_pkg::ubmu_sbus_s si;
      li = ~l;
      si = ~s;
      li.valid = 1'b0;
      si.valid = 1'b0;
      @(posedge clock_i);
      lbus_o <= l;
      sbus_o <= s;
      @(posedge clock_i);
      lbus_o <= li;
      sbus_o <= si;
   endtask
endmodule
`default_nettype wire

// [verif/test_user_break_match_unit.sv]
// Self-checking bench for the user break match unit.
// Assumes the bus model and the bound port checker are compiled.
`default_nettype none
module test_user_break_match_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [4:0] reg_addr_i = 5'h00;
   logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o, rv, r;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, break_req_o, irq_o, ha, hb;
   logic [31:0] seed = 32'h000102B4;
   logic [3:0] flags, msk;
   int failures = 0, compares = 0;
   logic [4:0] regs [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08,
      5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h11, 5'h1F};
   logic [8:0] corner [4] = '{9'h1CF, 9'h1F3, 9'h1FC, 9'h03F};
   ubmu_pkg::ubmu_lbus_s lbus_i, l;
   ubmu_pkg::ubmu_sbus_s sbus_i, s;
   ubmu_pkg::ubmu_chan_s ca, cb;
   initial forever #20 clock_i = ~clock_i;
   ubmu_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .lbus_i(lbus_i), .sbus_i(sbus_i), .break_req_o(break_req_o),
      .irq_o(irq_o));
   ubmu_bus_model bus_u (.clock_i(clock_i), .lbus_o(lbus_i),
      .sbus_o(sbus_i));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Readable bits of each index; unmapped and flags read as zero here
   function automatic logic [31:0] rmask(logic [4:0] a);
      case (a)
         ubmu_pkg::A_CYC_COND, ubmu_pkg::B_CYC_COND: return 32'h000001FF;
         ubmu_pkg::IRQ_MASK: return 32'h0000000F;
         ubmu_pkg::BRK_CTRL, 5'h1F: return 32'h00000000;
         default: return 32'hFFFFFFFF;
      endcase
   endfunction
   // expected hit of one channel on one beat
   function automatic logic hit(ubmu_pkg::ubmu_chan_s c, logic sy,
         logic [31:0] a, logic [31:0] d, logic w, logic f, logic [1:0] m);
      return ((a ^ c.addr) & ~c.addr_msk) == 32'h0
         && ((d ^ c.data) & ~c.data_msk) == 32'h0 && c.cond[sy]
         && c.cond[ubmu_pkg::CC_FD_LSB + !f] && c.cond[4 + w]
         && (!sy || c.cond[ubmu_pkg::CC_MS_LSB + m]);
   endfunction
   task automatic check(string n, logic [31:0] seen, logic [31:0] ex);
      compares++;
      if (seen !== ex) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, ex, seen);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [31:0] d);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a, output logic [31:0] d);
      @(posedge clock_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic prog(ubmu_pkg::ubmu_chan_s c, logic [4:0] b);
      wr(b, c.addr);
      wr(b + 5'h01, c.addr_msk);
      wr(b + 5'h02, c.data);
      wr(b + 5'h03, c.data_msk);
      wr(b + 5'h04, {23'h000000, c.cond});
   endtask
   task automatic final_report();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clock_i);
      failures++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      foreach (regs[i]) begin
         rd(regs[i], rv);
         check("reset value", rv, 32'h00000000);
         r = rnd();
         wr(regs[i], r);
         rd(regs[i], rv);
         check("readback", rv, r & rmask(regs[i]));
      end
      $display("test registers done");
      flags = 4'h0;
      for (int n = 0; n < 300; n++) begin
         ca.addr = rnd();
         ca.addr_msk = rnd() & rnd();
         ca.data = rnd();
         ca.data_msk = rnd() & rnd();
         r = rnd() | rnd();
         ca.cond = (n < 4) ? corner[n] : r[8:0];
         cb = ca;
         r = rnd() | rnd();
         cb.cond = r[8:0];
         prog(ca, ubmu_pkg::A_BRK_ADDR);
         prog(cb, ubmu_pkg::B_BRK_ADDR);
         r = rnd();
         msk = r[3:0];
         wr(ubmu_pkg::IRQ_MASK, {28'h0000000, msk});
         r = rnd();
         l.valid = r[0];
         l.addr = ca.addr ^ (rnd() & ca.addr_msk) ^ {31'h0, r[1] & r[2]};
         l.data = ca.data ^ (rnd() & ca.data_msk) ^ {31'h0, r[3] & r[4]};
         l.write = r[5];
         l.fetch = r[6];
         s = {r[7], l.addr, l.data, r[8],
            (r[10:9] == 2'h3) ? 2'h0 : r[10:9], r[11]};
         // fill from the transfer controller is data
         ha = l.valid && hit(ca, 0, l.addr, l.data, l.write, l.fetch, 0)
            || s.valid && hit(ca, 1, s.addr, s.data, s.write,
            s.fetch_fill && s.master != ubmu_pkg::MST_XFER, s.master);
         hb = l.valid && hit(cb, 0, l.addr, l.data, l.write, l.fetch, 0)
            || s.valid && hit(cb, 1, s.addr, s.data, s.write,
            s.fetch_fill && s.master != ubmu_pkg::MST_XFER, s.master);
         bus_u.beat(l, s);
         #1 check("break request", {31'h0, break_req_o},
            {31'h0, ha | hb});
         flags |= {hb, ha, hb, ha};
         rd(ubmu_pkg::BRK_CTRL, rv);
         check("match flags", rv, {28'h0, flags});
         check("interrupt", {31'h0, irq_o}, {31'h0, |(flags & msk)});
         if (r[12]) begin
            r = rnd();
            wr(ubmu_pkg::BRK_CTRL, r);
            flags &= r[3:0];
         end
      end
      $display("test matching done");
      final_report();
   end
endmodule
`default_nettype wire
